// ---- hw/port_override_pkg.sv ----
// Package with register offsets, field positions and reset values of the port override block.
package port_override_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] DIR_OFFSET      = 12'h000;
    localparam logic [11:0] OUT_OFFSET      = 12'h004;
    localparam logic [11:0] PULLUP_OFFSET   = 12'h008;
    localparam logic [11:0] SAMPLE_OFFSET   = 12'h00C;
    localparam logic [11:0] CTRL_OFFSET     = 12'h010;
    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int          PIN_COUNT       = 8;
    localparam int          CTRL_REF_BIT    = 0;
    localparam int          CTRL_PCIE_BIT   = 1;
    localparam int          CTRL_SLEEP_BIT  = 2;
    localparam logic [7:0]  DIR_RESET       = 8'h00;
    localparam logic [7:0]  OUT_RESET       = 8'h00;
    localparam logic [7:0]  PULLUP_RESET    = 8'h00;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;
    localparam int          REF_PIN         = 0;
    localparam int          RX_PIN          = 7;
    localparam int          TIMER0_OUT_PIN  = 5;
    localparam int          TIMER1_OUT_PIN  = 6;
    localparam int          TIMER0_SRC_PIN  = 4;
    localparam int          TIMER1_SRC_PIN  = 3;
endpackage

// ---- hw/port_alternate_function_override.sv ----
// Port override logic that lets peripherals take control of the first port's eight pins.
//
// Notes on behaviour
// - Pull-up follows override value when enabled, else the pull-up register bit.
// - With pull-up override enabled, register pull-up bits are ignored except on pin 7, whose override value is its own pull-up bit.
// - Output driver enable comes from direction override value when enabled, else direction bit.
// - With direction override active, the direction bit is ignored.
// - Driven value comes from value override when enabled, else output value bit.
// - With value override enabled, pin value equals override value.
// - Toggle override from a peripheral inverts the stored output value bit.
// - Input enable follows its override when enabled, else normal/sleep state decides.
// - With input enable override active, sleep state does not matter.
// - Raw input to peripherals is tapped before the port synchroniser.
// - Peripherals synchronise raw input themselves unless it is a clock source.
// - Strobes shared per port, clock and sleep clamp shared, other controls per pin.
// - Timer and receiver override signals are made inside the owning peripheral; REF and PCIE overrides come from the CTRL register here.
// - Analog path goes straight to the pad, both directions.
// - Pin 0 used as analog reference disables its pull-up and output driver.
// - Pins 0 to 7 are pin-change sources 0 to 7 of group 0.
// - Pin 5 carries timer 0 match B, pin 6 timer 1 match B.
// - Pin 4 feeds timer 0 count source, pin 3 timer 1 count source.
// - Pin 7 gives the serial port 0 receive input.
// - Pins 1,2 comparator inputs; pin 3 channel 0 and touch; pins 4-7 channels 1-4.
// - A pin carries only the overrides its own functions need.
// - Direction one makes an output, zero an input.
// - Writing one to an input sample bit toggles the output value bit.
// - Sleep controller clamp disables inputs in deep sleep unless overridden.
`timescale 1ns/1ns
`default_nettype none
module port_alternate_function_override (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sleep_clamp_i,
    input  wire logic [7:0]  pad_in_i,
    output logic      [7:0]  pad_out_o,
    output logic      [7:0]  pad_oe_o,
    output logic      [7:0]  pad_pullup_o,
    output logic      [7:0]  pad_input_en_o,
    input  wire logic        uart0_rx_en_i,
    input  wire logic        timer0_match_b_en_i,
    input  wire logic        timer0_match_b_out_i,
    input  wire logic        timer1_match_b_en_i,
    input  wire logic        timer1_match_b_out_i,
    input  wire logic [7:0]  toggle_override_en_i,
    input  wire logic [7:0]  analog_in_disable_i,
    output logic      [7:0]  alt_raw_input_o,
    output logic      [7:0]  pin_change_src_o,
    output logic             timer0_count_source_o,
    output logic             timer1_count_source_o,
    output logic             uart0_receive_in_o,
    output logic             pin_change_enable_o
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] direction_bit_r;
    logic [7:0] output_value_bit_r;
    logic [7:0] pullup_bit_r;
    logic [7:0] sync_stage_r;
    logic [7:0] input_sample_bit_r;
    logic [2:0] ctrl_r;
    logic       wr_en;
    logic       rd_en;
    logic       ref_active;
    logic       rd_valid_r;

    // Per-pin override enables and values; unused ones stay zero.
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
    logic [7:0] direction_override_en;
    logic [7:0] direction_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] input_en_override_en;
    logic [7:0] input_en_override_val;

    // One shared write and read strobe serve all pins of the port.
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    // Reads take one wait state so that the registered read data stands when pready is seen.
    assign pready_o  = ~rd_en | rd_valid_r;
    assign ref_active = ctrl_r[port_override_pkg::CTRL_REF_BIT];

    // ----------------------------------------------------------------
    // Override sources per pin
    // ----------------------------------------------------------------
    // Timer and receiver overrides are computed by the peripherals; the REF and PCIE overrides are made here from ctrl_r.
    always_comb begin
        pullup_override_en     = 8'h00;
        pullup_override_val    = 8'h00;
        direction_override_en  = 8'h00;
        direction_override_val = 8'h00;
        value_override_en      = 8'h00;
        value_override_val     = 8'h00;
        pullup_override_en[port_override_pkg::REF_PIN]    = ref_active;
        direction_override_en[port_override_pkg::REF_PIN] = ref_active;
        value_override_en[port_override_pkg::REF_PIN]     = ref_active;
        pullup_override_en[port_override_pkg::RX_PIN]     = uart0_rx_en_i;
        pullup_override_val[port_override_pkg::RX_PIN]    =
            pullup_bit_r[port_override_pkg::RX_PIN];
        direction_override_en[port_override_pkg::RX_PIN]  = uart0_rx_en_i;
        value_override_en[port_override_pkg::TIMER0_OUT_PIN]  = timer0_match_b_en_i;
        value_override_val[port_override_pkg::TIMER0_OUT_PIN] = timer0_match_b_out_i;
        value_override_en[port_override_pkg::TIMER1_OUT_PIN]  = timer1_match_b_en_i;
        value_override_val[port_override_pkg::TIMER1_OUT_PIN] = timer1_match_b_out_i;
        // Pin-change enable and analog disable both lift the sleep clamp decision.
        input_en_override_val = pin_change_enable_o ? 8'hFF : 8'h00;
        input_en_override_en  = input_en_override_val | analog_in_disable_i;
    end

    // ----------------------------------------------------------------
    // Pad control, purely combinational
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < port_override_pkg::PIN_COUNT; g++) begin : g_pin
            always_comb begin
                pad_pullup_o[g] = pullup_override_en[g] ? pullup_override_val[g]
                                                        : pullup_bit_r[g];
                pad_oe_o[g] = direction_override_en[g] ? direction_override_val[g]
                                                       : direction_bit_r[g];
                pad_out_o[g] = value_override_en[g] ? value_override_val[g]
                                                    : output_value_bit_r[g];
                pad_input_en_o[g] = input_en_override_en[g] ? input_en_override_val[g]
                                                            : ~sleep_clamp_i;
                // Clamped inputs read as low, so a floating pad draws no current.
                alt_raw_input_o[g] = pad_in_i[g] & pad_input_en_o[g];
            end
        end
    endgenerate

    // Analog signals stay in the pad ring; nothing digital sits on them.
    assign pin_change_src_o      = alt_raw_input_o;
    assign timer0_count_source_o = alt_raw_input_o[port_override_pkg::TIMER0_SRC_PIN];
    assign timer1_count_source_o = alt_raw_input_o[port_override_pkg::TIMER1_SRC_PIN];
    assign uart0_receive_in_o    = alt_raw_input_o[port_override_pkg::RX_PIN];
    assign pin_change_enable_o   = ctrl_r[port_override_pkg::CTRL_PCIE_BIT];
    assign pslverr_o = psel_i & penable_i & (paddr_i[1:0] != 2'h0 ||
                       paddr_i > port_override_pkg::CTRL_OFFSET);

    // ----------------------------------------------------------------
    // Register updates
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            direction_bit_r <= port_override_pkg::DIR_RESET;
            pullup_bit_r    <= port_override_pkg::PULLUP_RESET;
            ctrl_r          <= port_override_pkg::CTRL_RESET;
        end else if (wr_en) begin
            if (paddr_i == port_override_pkg::DIR_OFFSET) begin
                direction_bit_r <= pwdata_i[7:0];
            end
            if (paddr_i == port_override_pkg::PULLUP_OFFSET) begin
                pullup_bit_r <= pwdata_i[7:0];
            end
            if (paddr_i == port_override_pkg::CTRL_OFFSET) begin
                ctrl_r <= pwdata_i[2:0];
            end
        end
    end

    // A register write and a toggle in the same cycle: toggle applies to the new value.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            output_value_bit_r <= port_override_pkg::OUT_RESET;
        end else if (wr_en && paddr_i == port_override_pkg::OUT_OFFSET) begin
            output_value_bit_r <= pwdata_i[7:0] ^ toggle_override_en_i;
        end else if (wr_en && paddr_i == port_override_pkg::SAMPLE_OFFSET) begin
            output_value_bit_r <= output_value_bit_r ^ pwdata_i[7:0]
                                  ^ toggle_override_en_i;
        end else begin
            output_value_bit_r <= output_value_bit_r ^ toggle_override_en_i;
        end
    end

    // Two-stage synchroniser for software reads; peripherals bypass it.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sync_stage_r       <= 8'h00;
            input_sample_bit_r <= 8'h00;
        end else begin
            sync_stage_r       <= alt_raw_input_o;
            input_sample_bit_r <= sync_stage_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_en & ~rd_valid_r;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (rd_en && !rd_valid_r) begin
            unique case (paddr_i)
                port_override_pkg::DIR_OFFSET:    prdata_o <= {24'h000000, direction_bit_r};
                port_override_pkg::OUT_OFFSET:    prdata_o <= {24'h000000, output_value_bit_r};
                port_override_pkg::PULLUP_OFFSET: prdata_o <= {24'h000000, pullup_bit_r};
                port_override_pkg::SAMPLE_OFFSET: prdata_o <= {24'h000000, input_sample_bit_r};
                port_override_pkg::CTRL_OFFSET:   prdata_o <= {29'h0, ctrl_r};
                default:                          prdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- dv/port_override_assertions.sv ----
// Checker of the port override block's pad, routing and input-enable relations.
`timescale 1ns/1ns
`default_nettype none
module port_override_chk (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       psel_i,
    input wire logic       sleep_clamp_i,
    input wire logic       uart0_rx_en_i,
    input wire logic       timer0_match_b_en_i,
    input wire logic       timer0_match_b_out_i,
    input wire logic       timer0_count_source_o,
    input wire logic       timer1_count_source_o,
    input wire logic       uart0_receive_in_o,
    input wire logic       pin_change_enable_o,
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] pad_out_o,
    input wire logic [7:0] pad_oe_o,
    input wire logic [7:0] pad_input_en_o,
    input wire logic [7:0] toggle_override_en_i,
    input wire logic [7:0] analog_in_disable_i,
    input wire logic [7:0] alt_raw_input_o,
    input wire logic [7:0] pin_change_src_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // No bus access in the toggle cycle, so no register write can mask the flip.
    sequence s_toggle_req;
        toggle_override_en_i[2] && !psel_i;
    endsequence
    a_raw_input_gate: assert property (alt_raw_input_o == (pad_in_i & pad_input_en_o))
        else $error("raw input gate");
    a_pc_src_map: assert property (pin_change_src_o == alt_raw_input_o)
        else $error("pin change map");
    a_alt_src_map: assert property (
        timer0_count_source_o == alt_raw_input_o[4] && timer1_count_source_o == alt_raw_input_o[3]
        && uart0_receive_in_o == alt_raw_input_o[7]) else $error("alternate source map");
    a_t0_value_ovr: assert property (
        timer0_match_b_en_i |-> pad_out_o[5] == timer0_match_b_out_i) else $error("timer value");
    a_uart_dir_ovr: assert property (uart0_rx_en_i |-> !pad_oe_o[7])
        else $error("receive pin driven");
    a_input_ovr_on: assert property (pin_change_enable_o |-> pad_input_en_o == 8'hFF)
        else $error("input override");
    a_sleep_clamp: assert property (
        !pin_change_enable_o && sleep_clamp_i |-> pad_input_en_o == 8'h00) else $error("clamp");
    a_analog_dis: assert property (
        !pin_change_enable_o && !sleep_clamp_i |-> pad_input_en_o == ~analog_in_disable_i)
        else $error("input disable");
    a_toggle_flip: assert property (s_toggle_req |=> pad_out_o[2] != $past(pad_out_o[2]))
        else $error("toggle lost");
endmodule
bind port_alternate_function_override port_override_chk u_chk (.*);
`default_nettype wire

// ---- dv/periph_pad_model.sv ----
// Model of the peripherals and the pad beyond the port override block.
`timescale 1ns/1ns
`default_nettype none
module periph_pad_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] drv_val_i,
    input  wire logic [7:0] drv_en_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] pad_o,
    output logic            t0_out_o,
    output logic            t1_out_o
);
    logic [1:0] div_r   = 2'h0;
    logic [7:0] float_r = 8'h5A;
    // Timers make their own match outputs; the port only routes them.
    always @(posedge clock_i) begin
        div_r   <= div_r + 2'h1;
        float_r <= ~float_r;
    end
    assign t0_out_o = div_r[0];
    assign t1_out_o = div_r[1];
    // A floating pad drifts every cycle so a stale level never passes for a real one.
    assign pad_o = (drv_en_i & drv_val_i) | (~drv_en_i & ext_en_i & ext_val_i)
                 | (~drv_en_i & ~ext_en_i & (pullup_i | float_r));
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the port override block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct {int sel; logic [31:0] exp;} note_t;
    logic        clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, sleep_clamp_i = 1'b0, uart0_rx_en_i = 1'b0;
    logic        timer0_match_b_en_i = 1'b0, timer1_match_b_en_i = 1'b0, pready_o, pslverr_o;
    logic        timer0_match_b_out_i, timer1_match_b_out_i, pin_change_enable_o;
    logic        timer0_count_source_o, timer1_count_source_o, uart0_receive_in_o;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, prdata_o, o, m, v, a, e, rd_data = 32'h0;
    logic        slv = 1'b0;
    logic [7:0]  toggle_override_en_i = 8'h00, analog_in_disable_i = 8'h00, ext_val = 8'h00;
    logic [7:0]  ext_en = 8'h00, pad_in_i, pad_out_o, pad_oe_o, pad_pullup_o, pad_input_en_o;
    logic [7:0]  alt_raw_input_o, pin_change_src_o;
    int          seed = 91, errors = 0, n_tests = 0, cyc = 0;
    note_t       q[$];
    note_t       nt;
    port_alternate_function_override DUT (.*);
    periph_pad_model u_far (.clock_i(clock_i), .drv_val_i(pad_out_o), .drv_en_i(pad_oe_o),
        .pullup_i(pad_pullup_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pad_in_i),
        .t0_out_o(timer0_match_b_out_i), .t1_out_o(timer1_match_b_out_i));
    initial forever #5 clock_i = ~clock_i;
    function automatic logic [31:0] obs(input int s);
        logic [7:0] w [6];
        w = '{pad_oe_o, pad_out_o, pad_pullup_o, pad_input_en_o, alt_raw_input_o,
              {5'h00, uart0_receive_in_o, timer1_count_source_o, timer0_count_source_o}};
        return (s == 0) ? rd_data : (s == 7) ? {31'h0, slv} : {24'h000000, w[s-1]};
    endfunction
    task chk(input int s, input logic [31:0] x);
        q.push_back('{s, x});
    endtask
    task done(input string s);
        $display("test %0s finished", s);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // The request is held until pready is seen high; a new setup never shares a step.
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge clock_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= ad;
        pwdata_i  <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd_data = prdata_o;
        slv     = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Read data and pads are settled by the falling edge, so notes are compared there.
    always @(negedge clock_i) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            n_tests++;
            if (obs(nt.sel) !== nt.exp) begin
                errors++;
                $display("[ERR] %0t sel %0d exp %h got %h", $time, nt.sel, nt.exp, obs(nt.sel));
            end
        end
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        chk(1, 32'h0);
        chk(3, 32'h0);
        done("reset");
        v = $random(seed) & 32'hFF;
        o = $random(seed) & 32'hFF;
        m = $random(seed) & 32'hFF;
        apb(1'b1, port_override_pkg::DIR_OFFSET, v);
        apb(1'b1, port_override_pkg::OUT_OFFSET, o);
        apb(1'b1, port_override_pkg::PULLUP_OFFSET, m);
        chk(1, v);
        chk(2, o);
        chk(3, m);
        apb(1'b0, port_override_pkg::DIR_OFFSET, 32'h0);
        chk(0, v);
        apb(1'b1, port_override_pkg::SAMPLE_OFFSET, m);
        o = o ^ m;
        chk(2, o);
        @(posedge clock_i);
        toggle_override_en_i <= 8'h1C;
        @(posedge clock_i);
        toggle_override_en_i <= 8'h00;
        o = o ^ 32'h1C;
        chk(2, o);
        done("registers");
        apb(1'b1, port_override_pkg::DIR_OFFSET, 32'h60);
        timer0_match_b_en_i <= 1'b1;
        timer1_match_b_en_i <= 1'b1;
        @(posedge clock_i);
        #1;
        e = {25'h0, timer1_match_b_out_i, timer0_match_b_out_i, 5'h00};
        chk(2, (o & 32'h9F) | e);
        @(posedge clock_i);
        timer0_match_b_en_i <= 1'b0;
        timer1_match_b_en_i <= 1'b0;
        apb(1'b1, port_override_pkg::DIR_OFFSET, 32'hFF);
        apb(1'b1, port_override_pkg::OUT_OFFSET, 32'hFF);
        apb(1'b1, port_override_pkg::CTRL_OFFSET, 32'h1);
        chk(1, 32'hFE);
        chk(2, 32'hFE);
        chk(3, m & 32'hFE);
        apb(1'b1, port_override_pkg::CTRL_OFFSET, 32'h0);
        ext_en        <= 8'h80;
        ext_val       <= 8'h80;
        uart0_rx_en_i <= 1'b1;
        chk(1, 32'h7F);
        chk(6, 32'h7);
        done("overrides");
        v = $random(seed) & 32'hFF;
        apb(1'b1, port_override_pkg::DIR_OFFSET, 32'h0);
        uart0_rx_en_i <= 1'b0;
        ext_en        <= 8'hFF;
        ext_val       <= v[7:0];
        for (int i = 0; i < 4; i++) begin
            a = $random(seed) & 32'hFF;
            apb(1'b1, port_override_pkg::CTRL_OFFSET, (i > 1) ? 32'h2 : 32'h0);
            sleep_clamp_i       <= i[0];
            analog_in_disable_i <= a[7:0];
            e = (i > 1) ? 32'hFF : (i == 1) ? 32'h0 : ~a & 32'hFF;
            chk(4, e);
            chk(5, v & e);
        end
        done("input enable");
        apb(1'b1, 12'h014, 32'hFF);
        chk(7, 32'h1);
        apb(1'b0, 12'h014, 32'hFF);
        chk(0, 32'h0);
        apb(1'b0, port_override_pkg::DIR_OFFSET, 32'h0);
        chk(0, 32'h0);
        chk(7, 32'h0);
        done("unmapped");
        repeat (2) @(posedge clock_i);
        close_out();
    end
endmodule
`default_nettype wire
